// File: hw/seil_top.sv
// status registers, event latches and interrupt request of the pmic
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
`include "seil_defs.svh"

//////////////////////////////////////////////////////////////////////////////
// Function
// - irq asserted when unmasked event set
// - change of monitored signal sets event
// - irq held masked through power-up
// - write one clears, zero keeps
// - auto-incrementing consecutive reads
// - events during clearing delayed, never lost
// - charge complete flag, cleared on start
// - charge timeout flag, cleared on start/load
// - status bit 5 shows feedback pin
// - status bit 6 shows sequencer busy
// - status bit 7 shows comparator
// - low status: inputs 0-7, analog 0-2
// - high status: inputs 8-15
// - supply event bit assignment
// - floating id: both edges, falling in powerdown
// - grounded id: both edges
// - accessory and adc event assignment
// - low input events by active state
// - status reads show live levels
module seil_top #(
    parameter int GPI_N = 16
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // register port
    input wire seil_pkg::seil_byte_t i_addr,
    input wire seil_pkg::seil_byte_t i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic i_rd_next,
    output seil_pkg::seil_byte_t o_rd_data,
    // pins from outside the clock domain
    input wire logic [GPI_N-1:0] i_general_input,
    input wire logic i_power_key_n,
    input wire logic i_accessory_id_floating,
    input wire logic i_accessory_id_grounded,
    input wire logic i_sequencer_feedback_pin_level,
    // supply and sequencer logic
    input wire logic i_dc_adapter_detect,
    input wire logic i_vbus_detect,
    input wire logic i_system_rail_low,
    input wire logic i_rtc_alarm,
    input wire logic i_sequencer_stop,
    input wire logic i_sequencer_active,
    input wire logic i_reference_comparator,
    input wire logic i_powerup_active,
    input wire logic i_powerdown_mode,
    // charger logic
    input wire logic [2:0] i_charger_state,
    input wire logic i_charge_start,
    input wire logic i_charge_done,
    input wire logic i_charge_timeout,
    input wire logic i_charge_timer_load,
    input wire logic i_battery_temp_event,
    // adc logic
    input wire logic i_manual_conversion_done,
    input wire logic i_pen_down,
    input wire logic i_touch_sequence_done,
    input wire logic [2:0] i_analog_mode,
    input wire logic [2:0] i_analog_above_high,
    input wire logic [2:0] i_analog_cross,
    // interrupt
    output logic o_interrupt_request_n
);
    import seil_pkg::*;

    localparam int PN = `SEIL_PIN_N;

    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge history
    logic [PN-1:0] pins;
    logic [PN-1:0] sync1, sync2, sync3, stable, stable_d;
    logic [PN-1:0] next_stable;
    logic [4:0] lvl, lvl_d;
    logic [PN-1:0] rise, fall;
    logic [4:0] lrise, lfall;
    // declared early: edge history and event decode read them
    logic chg_complete, chg_timeout;
    seil_byte_t active_state;

    assign pins = {i_sequencer_feedback_pin_level, i_accessory_id_grounded,
        i_accessory_id_floating, i_power_key_n, i_general_input};
    assign lvl = {i_reference_comparator, chg_complete, i_system_rail_low,
        i_vbus_detect, i_dc_adapter_detect};

    // a bit moves only when the two later stages agree
    always_comb
    begin
        next_stable = (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & stable);
        rise = stable & ~stable_d;
        fall = ~stable & stable_d;
        lrise = lvl & ~lvl_d;
        lfall = ~lvl & lvl_d;
    end

    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            stable <= '0;
            stable_d <= '0;
            lvl_d <= '0;
        end
        else
        begin
            sync1 <= pins;
            sync2 <= sync1;
            sync3 <= sync2;
            stable <= next_stable;
            stable_d <= stable;
            lvl_d <= lvl;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // charger flags
    logic next_chg_complete, next_chg_timeout;

    // a finish in the start cycle still counts
    always_comb
    begin
        next_chg_complete = i_charge_done |
            (chg_complete & ~i_charge_start);
        next_chg_timeout = i_charge_timeout | (chg_timeout &
            ~(i_charge_start | i_charge_timer_load));
    end

    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            chg_complete <= 1'b0;
            chg_timeout <= 1'b0;
        end
        else
        begin
            chg_complete <= next_chg_complete;
            chg_timeout <= next_chg_timeout;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // event sources
    seil_byte_t new_a, new_b, new_c;
    logic float_evt;

    always_comb
    begin
        new_a = {lrise[4] | lfall[4], i_sequencer_stop, i_rtc_alarm,
            lrise[2], lfall[1], lfall[0], lrise[1], lrise[0]};
        float_evt = fall[`SEIL_PIN_FLOAT] |
            (rise[`SEIL_PIN_FLOAT] & ~i_powerdown_mode);
        new_b = {i_touch_sequence_done, i_pen_down,
            i_manual_conversion_done, i_battery_temp_event, lrise[3],
            rise[`SEIL_PIN_GND] | fall[`SEIL_PIN_GND],
            float_evt,
            rise[`SEIL_PIN_KEY] | fall[`SEIL_PIN_KEY]};
        for (int i = 0; i < 8; i++)
        begin
            new_c[i] = active_state[i] ? rise[i] : fall[i];
        end
        for (int i = 0; i < `SEIL_ANALOG_N; i++)
        begin
            if (i_analog_mode[i])
            begin
                new_c[i] = i_analog_cross[i];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // event latches, masks and configuration
    seil_byte_t ev_a, ev_b, ev_c, pend_a, pend_b, pend_c;
    seil_byte_t mask_a, mask_b, mask_c;
    seil_byte_t next_ev_a, next_ev_b, next_ev_c;
    seil_byte_t next_pend_a, next_pend_b, next_pend_c;
    seil_byte_t next_mask_a, next_mask_b, next_mask_c, next_active;
    logic wr_a, wr_b, wr_c;

    assign wr_a = i_wr_en && i_addr == `SEIL_OFS_EV_SUPPLY;
    assign wr_b = i_wr_en && i_addr == `SEIL_OFS_EV_ACC;
    assign wr_c = i_wr_en && i_addr == `SEIL_OFS_EV_IN_LOW;

    // new events are parked one cycle while their register is being
    // cleared, so a clear cannot swallow them
    always_comb
    begin
        next_ev_a = (ev_a & ~(wr_a ? i_wr_data : '0)) | pend_a;
        next_ev_b = (ev_b & ~(wr_b ? i_wr_data : '0)) | pend_b;
        next_ev_c = (ev_c & ~(wr_c ? i_wr_data : '0)) | pend_c;
        next_pend_a = wr_a ? new_a : '0;
        next_pend_b = wr_b ? new_b : '0;
        next_pend_c = wr_c ? new_c : '0;
        if (!wr_a)
        begin
            next_ev_a = next_ev_a | new_a;
        end
        if (!wr_b)
        begin
            next_ev_b = next_ev_b | new_b;
        end
        if (!wr_c)
        begin
            next_ev_c = next_ev_c | new_c;
        end
        next_mask_a = mask_a;
        next_mask_b = mask_b;
        next_mask_c = mask_c;
        next_active = active_state;
        if (i_wr_en)
        begin
            unique case (i_addr)
                `SEIL_OFS_MASK_SUPPLY: next_mask_a = i_wr_data;
                `SEIL_OFS_MASK_ACC: next_mask_b = i_wr_data;
                `SEIL_OFS_MASK_IN_LOW: next_mask_c = i_wr_data;
                `SEIL_OFS_ACTIVE_STATE: next_active = i_wr_data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            ev_a <= `SEIL_RST_EVENT;
            ev_b <= `SEIL_RST_EVENT;
            ev_c <= `SEIL_RST_EVENT;
            pend_a <= `SEIL_RST_EVENT;
            pend_b <= `SEIL_RST_EVENT;
            pend_c <= `SEIL_RST_EVENT;
            mask_a <= `SEIL_RST_MASK;
            mask_b <= `SEIL_RST_MASK;
            mask_c <= `SEIL_RST_MASK;
            active_state <= `SEIL_RST_ACTIVE;
        end
        else
        begin
            ev_a <= next_ev_a;
            ev_b <= next_ev_b;
            ev_c <= next_ev_c;
            pend_a <= next_pend_a;
            pend_b <= next_pend_b;
            pend_c <= next_pend_c;
            mask_a <= next_mask_a;
            mask_b <= next_mask_b;
            mask_c <= next_mask_c;
            active_state <= next_active;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // power-up hold and interrupt line
    seil_state_t state, next_state;
    logic any_event, unmasked, next_irq_n;

    assign any_event = |{ev_a, ev_b, ev_c, pend_a, pend_b, pend_c};
    assign unmasked = |{ev_a & ~mask_a, ev_b & ~mask_b, ev_c & ~mask_c};

    // release waits for a fully clean latch set, masked bits included
    always_comb
    begin
        next_state = state;
        unique case (state)
            SEIL_HOLD:
            begin
                if (!i_powerup_active && !any_event)
                begin
                    next_state = SEIL_RUN;
                end
            end
            SEIL_RUN:
            begin
                if (i_powerup_active)
                begin
                    next_state = SEIL_HOLD;
                end
            end
        endcase
        next_irq_n = !(state == SEIL_RUN && unmasked);
    end

    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state <= SEIL_HOLD;
            o_interrupt_request_n <= 1'b1;
        end
        else
        begin
            state <= next_state;
            o_interrupt_request_n <= next_irq_n;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read port
    seil_byte_t rd_ptr, next_rd_ptr, rd_addr, stat_low, stat_chg;
    seil_byte_t next_rd_data;

    assign rd_addr = i_rd_next ? rd_ptr : i_addr;

    always_comb
    begin
        stat_low = stable[7:0];
        for (int i = 0; i < `SEIL_ANALOG_N; i++)
        begin
            if (i_analog_mode[i])
            begin
                stat_low[i] = i_analog_above_high[i];
            end
        end
        stat_chg = {i_reference_comparator,
            i_sequencer_active,
            stable[`SEIL_PIN_FB],
            chg_timeout, chg_complete, i_charger_state};
        next_rd_ptr = rd_ptr;
        next_rd_data = `SEIL_RD_IDLE;
        if (i_rd_en || i_rd_next)
        begin
            next_rd_ptr = rd_addr + 8'h01;
            unique case (rd_addr)
                `SEIL_OFS_CHG_STAT: next_rd_data = stat_chg;
                `SEIL_OFS_STAT_LOW: next_rd_data = stat_low;
                `SEIL_OFS_STAT_HIGH: next_rd_data = stable[15:8];
                `SEIL_OFS_EV_SUPPLY: next_rd_data = ev_a;
                `SEIL_OFS_EV_ACC: next_rd_data = ev_b;
                `SEIL_OFS_EV_IN_LOW: next_rd_data = ev_c;
                `SEIL_OFS_MASK_SUPPLY: next_rd_data = mask_a;
                `SEIL_OFS_MASK_ACC: next_rd_data = mask_b;
                `SEIL_OFS_MASK_IN_LOW: next_rd_data = mask_c;
                `SEIL_OFS_ACTIVE_STATE: next_rd_data = active_state;
                default: next_rd_data = `SEIL_RD_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            rd_ptr <= 8'h00;
            o_rd_data <= `SEIL_RD_IDLE;
        end
        else
        begin
            rd_ptr <= next_rd_ptr;
            o_rd_data <= next_rd_data;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks
    chk_irq_assert: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        state == SEIL_RUN && unmasked |=> !o_interrupt_request_n)
        else $error("irq not asserted for unmasked event");
    chk_irq_release: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        !unmasked |=> o_interrupt_request_n)
        else $error("irq not released");
    chk_hold_masks: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        state == SEIL_HOLD |=> o_interrupt_request_n)
        else $error("irq escaped power-up hold");
    chk_clear_ones: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        wr_a && pend_a == 8'h00 |=> (ev_a & $past(i_wr_data)) == 8'h00)
        else $error("written one did not clear");
    chk_keep_zeros: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        wr_b |=> ($past(ev_b) & ~$past(i_wr_data) & ~ev_b) == 8'h00)
        else $error("written zero changed event");
    chk_event_kept: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        wr_a && new_a != 8'h00 |=> ##1 (ev_a & $past(new_a, 2)) != 8'h00)
        else $error("event lost during clear");
    chk_sticky_bits: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        !wr_c |=> ($past(ev_c) & ~ev_c) == 8'h00)
        else $error("event dropped without clear");
    chk_dc_event: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        lrise[0] && !wr_a |=> ev_a[0])
        else $error("dc detect event missing");
    chk_float_pd: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        i_powerdown_mode && rise[`SEIL_PIN_FLOAT] && !ev_b[1] && !pend_b[1]
        && !wr_b && !i_pen_down |=> !ev_b[1])
        else $error("floating rise latched in powerdown");
    chk_chg_start: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        i_charge_start && !i_charge_done |=> ##1 !o_rd_data[3] || !$past(i_rd_en)
        || $past(i_addr) != `SEIL_OFS_CHG_STAT || $past(i_charge_done))
        else $error("charge complete not cleared");
    chk_high_read: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        i_rd_en && i_addr == `SEIL_OFS_STAT_HIGH |=>
        o_rd_data == $past(stable[15:8]))
        else $error("high status read wrong");
endmodule

// File: hw/seil_defs.svh
// register map and field positions of the status and event block
`ifndef SEIL_DEFS_SVH
`define SEIL_DEFS_SVH
`define SEIL_ADDR_W 8
`define SEIL_DATA_W 8
// printed offsets
`define SEIL_OFS_STAT_LOW 8'h03
`define SEIL_OFS_STAT_HIGH 8'h04
`define SEIL_OFS_EV_SUPPLY 8'h05
`define SEIL_OFS_EV_ACC 8'h06
`define SEIL_OFS_EV_IN_LOW 8'h07
// chosen offsets
`define SEIL_OFS_CHG_STAT 8'h02
`define SEIL_OFS_MASK_SUPPLY 8'h0A
`define SEIL_OFS_MASK_ACC 8'h0B
`define SEIL_OFS_MASK_IN_LOW 8'h0C
`define SEIL_OFS_ACTIVE_STATE 8'h0D
// reset values
`define SEIL_RST_MASK 8'h00
`define SEIL_RST_ACTIVE 8'hFF
`define SEIL_RST_EVENT 8'h00
`define SEIL_RD_IDLE 8'h00
// charger and sequencer status fields
`define SEIL_CHG_COMPLETE_BIT 3
`define SEIL_CHG_TIMEOUT_BIT 4
`define SEIL_SEQ_FB_BIT 5
`define SEIL_SEQ_ACTIVE_BIT 6
`define SEIL_COMP_BIT 7
// accessory event fields
`define SEIL_ACC_FLOAT_BIT 1
`define SEIL_ACC_GND_BIT 2
// number of analog-capable general inputs
`define SEIL_ANALOG_N 3
// synchronised pin vector layout
`define SEIL_PIN_KEY 16
`define SEIL_PIN_FLOAT 17
`define SEIL_PIN_GND 18
`define SEIL_PIN_FB 19
`define SEIL_PIN_N 20
`endif

// File: hw/seil_pkg.sv
// types shared by the status and event block
package seil_pkg;
    typedef logic [7:0] seil_byte_t;
    typedef enum logic [0:0]
    {
        SEIL_HOLD = 1'b0,
        SEIL_RUN = 1'b1
    } seil_state_t;
endpackage

// File: tb/seil_host_model.sv
// host-side model: register master of the status and event block
`timescale 1ns/10ps
module seil_host_model (
    // clock
    input wire logic i_ref_clk,
    // register port toward the device
    output seil_pkg::seil_byte_t o_addr,
    output seil_pkg::seil_byte_t o_wr_data,
    output logic o_wr_en,
    output logic o_rd_en,
    output logic o_rd_next,
    input wire seil_pkg::seil_byte_t i_rd_data
);
    import seil_pkg::*;
    initial
    begin
        o_addr = 8'h00;
        o_wr_data = 8'h00;
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_rd_next = 1'b0;
    end
    //////////////////////////////////////////////////////////////////////
    // one-cycle strobes, the device never stalls
    task automatic wr(input seil_byte_t a, input seil_byte_t d);
        @(posedge i_ref_clk);
        o_addr <= a;
        o_wr_data <= d;
        o_wr_en <= 1'b1;
        @(posedge i_ref_clk);
        o_wr_en <= 1'b0;
    endtask
    // data stands only in the cycle after the strobe
    task automatic rd(input seil_byte_t a, output seil_byte_t d);
        @(posedge i_ref_clk);
        o_addr <= a;
        o_rd_en <= 1'b1;
        @(posedge i_ref_clk);
        o_rd_en <= 1'b0;
        #1 d = i_rd_data;
    endtask
    // three registers in one auto-incrementing run
    task automatic burst(input seil_byte_t a, output seil_byte_t d [3]);
        @(posedge i_ref_clk);
        o_addr <= a;
        o_rd_en <= 1'b1;
        @(posedge i_ref_clk);
        o_rd_en <= 1'b0;
        o_rd_next <= 1'b1;
        #1 d[0] = i_rd_data;
        @(posedge i_ref_clk);
        #1 d[1] = i_rd_data;
        @(posedge i_ref_clk);
        o_rd_next <= 1'b0;
        #1 d[2] = i_rd_data;
    endtask
endmodule

// File: tb/tb.sv
// self-checking bench of the status and event block
`timescale 1ns/10ps
`include "seil_defs.svh"
module tb;
    import seil_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_reset = 1'b1;
    seil_byte_t addr, wdat, rdat, d;
    seil_byte_t b [3];
    logic wr_en, rd_en, rd_next, irq_n;
    logic [15:0] gpi = 16'h0000;
    logic [9:0] pls = 10'h000;
    // key_n idles high, power-up in progress
    logic [10:0] lv = 11'h0A0;
    logic [2:0] chg = 3'b000;
    logic [2:0] amode = 3'b000;
    logic [2:0] ahigh = 3'b000;
    logic [2:0] across = 3'b000;
    int num_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int lb [18] = '{0, 1, 0, 1, 2, 2, 3, 3, 7, 7, 8, 8, 6, 8, 8, 6, 9, 9};
    logic [17:0] lval = 18'h1_3653;
    logic [17:0] lacc = 18'h3_FF00;
    seil_byte_t le [18] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h00,
        8'h80, 8'h80, 8'h01, 8'h01, 8'h02, 8'h02, 8'h00, 8'h00, 8'h02,
        8'h00, 8'h04, 8'h04};
    int pb [6] = '{0, 1, 6, 7, 8, 9};
    seil_byte_t pe [6] = '{8'h20, 8'h40, 8'h10, 8'h20, 8'h40, 8'h80};

    always #50 i_ref_clk = ~i_ref_clk;

    seil_host_model i_seil_host_model (.i_ref_clk(i_ref_clk), .o_addr(addr),
        .o_wr_data(wdat), .o_wr_en(wr_en), .o_rd_en(rd_en),
        .o_rd_next(rd_next), .i_rd_data(rdat));

    seil_top i_seil_top (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_addr(addr), .i_wr_data(wdat), .i_wr_en(wr_en), .i_rd_en(rd_en),
        .i_rd_next(rd_next), .o_rd_data(rdat), .i_general_input(gpi),
        .i_power_key_n(lv[7]), .i_accessory_id_floating(lv[8]),
        .i_accessory_id_grounded(lv[9]),
        .i_sequencer_feedback_pin_level(lv[10]),
        .i_dc_adapter_detect(lv[0]), .i_vbus_detect(lv[1]),
        .i_system_rail_low(lv[2]), .i_rtc_alarm(pls[0]),
        .i_sequencer_stop(pls[1]), .i_sequencer_active(lv[4]),
        .i_reference_comparator(lv[3]), .i_powerup_active(lv[5]),
        .i_powerdown_mode(lv[6]), .i_charger_state(chg),
        .i_charge_start(pls[2]), .i_charge_done(pls[3]),
        .i_charge_timeout(pls[4]), .i_charge_timer_load(pls[5]),
        .i_battery_temp_event(pls[6]), .i_manual_conversion_done(pls[7]),
        .i_pen_down(pls[8]), .i_touch_sequence_done(pls[9]),
        .i_analog_mode(amode), .i_analog_above_high(ahigh),
        .i_analog_cross(across), .o_interrupt_request_n(irq_n));

    //////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input seil_byte_t seen, input seil_byte_t exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    // pin sources pass a 3-flop sync, so settle generously
    task automatic pulse(input int n);
        @(posedge i_ref_clk);
        pls[n] <= 1'b1;
        @(posedge i_ref_clk);
        pls[n] <= 1'b0;
        wait_cyc(8);
    endtask
    task automatic level(input int n, input logic v);
        @(posedge i_ref_clk);
        lv[n] <= v;
        wait_cyc(8);
    endtask
    // clear only what was seen, so no stray bit is lost
    task automatic ev(input seil_byte_t a, input seil_byte_t exp);
        i_seil_host_model.rd(a, d);
        chk(d, exp);
        i_seil_host_model.wr(a, d);
    endtask
    task automatic irq(input logic exp);
        wait_cyc(3);
        chk({7'h00, irq_n}, {7'h00, exp});
    endtask

    always @(posedge i_ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            summarize();
        end
    end

    //////////////////////////////////////////////////////////////////////
    initial
    begin
        wait_cyc(2);
        i_reset <= 1'b0;
        wait_cyc(10);
        irq(1'b1);
        i_seil_host_model.rd(`SEIL_OFS_MASK_SUPPLY, d);
        chk(d, `SEIL_RST_MASK);
        i_seil_host_model.rd(`SEIL_OFS_ACTIVE_STATE, d);
        chk(d, `SEIL_RST_ACTIVE);
        level(5, 1'b0);
        irq(1'b1);
        ev(`SEIL_OFS_EV_ACC, 8'h01);
        irq(1'b1);
        pulse(0);
        irq(1'b0);
        i_seil_host_model.wr(`SEIL_OFS_MASK_SUPPLY, 8'h20);
        irq(1'b1);
        i_seil_host_model.wr(`SEIL_OFS_MASK_SUPPLY, 8'h00);
        irq(1'b0);
        i_seil_host_model.wr(`SEIL_OFS_EV_SUPPLY, 8'hDF);
        ev(`SEIL_OFS_EV_SUPPLY, 8'h20);
        irq(1'b1);
        for (int i = 0; i < 18; i++)
        begin
            level(lb[i], lval[i]);
            ev(lacc[i] ? `SEIL_OFS_EV_ACC : `SEIL_OFS_EV_SUPPLY, le[i]);
        end
        for (int i = 0; i < 6; i++)
        begin
            pulse(pb[i]);
            ev(i < 2 ? `SEIL_OFS_EV_SUPPLY : `SEIL_OFS_EV_ACC, pe[i]);
        end
        @(posedge i_ref_clk);
        chg <= 3'b101;
        lv[4] <= 1'b1;
        lv[10] <= 1'b1;
        lv[3] <= 1'b1;
        pulse(3);
        i_seil_host_model.rd(`SEIL_OFS_CHG_STAT, d);
        chk(d, 8'hED);
        ev(`SEIL_OFS_EV_ACC, 8'h08);
        ev(`SEIL_OFS_EV_SUPPLY, 8'h80);
        pulse(4);
        i_seil_host_model.rd(`SEIL_OFS_CHG_STAT, d);
        chk(d, 8'hFD);
        pulse(5);
        i_seil_host_model.rd(`SEIL_OFS_CHG_STAT, d);
        chk(d, 8'hED);
        pulse(4);
        pulse(2);
        i_seil_host_model.rd(`SEIL_OFS_CHG_STAT, d);
        chk(d, 8'hE5);
        @(posedge i_ref_clk);
        gpi <= 16'hA5C3;
        wait_cyc(8);
        i_seil_host_model.rd(`SEIL_OFS_STAT_LOW, d);
        chk(d, 8'hC3);
        i_seil_host_model.rd(`SEIL_OFS_STAT_HIGH, d);
        chk(d, 8'hA5);
        ev(`SEIL_OFS_EV_IN_LOW, 8'hC3);
        i_seil_host_model.wr(`SEIL_OFS_ACTIVE_STATE, 8'h00);
        @(posedge i_ref_clk);
        gpi <= 16'hA500;
        wait_cyc(8);
        ev(`SEIL_OFS_EV_IN_LOW, 8'hC3);
        @(posedge i_ref_clk);
        amode <= 3'b111;
        ahigh <= 3'b010;
        wait_cyc(8);
        i_seil_host_model.rd(`SEIL_OFS_STAT_LOW, d);
        chk(d, 8'h02);
        i_seil_host_model.wr(`SEIL_OFS_EV_IN_LOW, 8'hFF);
        @(posedge i_ref_clk);
        across <= 3'b101;
        @(posedge i_ref_clk);
        across <= 3'b000;
        wait_cyc(4);
        ev(`SEIL_OFS_EV_IN_LOW, 8'h05);
        // burst over all three latches
        pulse(0);
        pulse(8);
        @(posedge i_ref_clk);
        across <= 3'b001;
        @(posedge i_ref_clk);
        across <= 3'b000;
        wait_cyc(4);
        i_seil_host_model.burst(`SEIL_OFS_EV_SUPPLY, b);
        chk(b[0], 8'h20);
        chk(b[1], 8'h40);
        chk(b[2], 8'h01);
        @(posedge i_ref_clk);
        #1 chk(rdat, `SEIL_RD_IDLE);
        // new event landing on the clear cycle or just after it
        for (int k = 0; k < 2; k++)
        begin
            fork
                i_seil_host_model.wr(`SEIL_OFS_EV_SUPPLY, 8'h20);
                begin
                    repeat (k + 1) @(posedge i_ref_clk);
                    pls[0] <= 1'b1;
                    @(posedge i_ref_clk);
                    pls[0] <= 1'b0;
                end
            join
            wait_cyc(4);
            ev(`SEIL_OFS_EV_SUPPLY, 8'h20);
        end
        i_seil_host_model.wr(`SEIL_OFS_EV_ACC, 8'hFF);
        i_seil_host_model.wr(`SEIL_OFS_EV_IN_LOW, 8'hFF);
        i_seil_host_model.rd(8'h55, d);
        chk(d, `SEIL_RD_IDLE);
        // second reset mid-run re-enters the power-up hold
        @(posedge i_ref_clk);
        i_reset <= 1'b1;
        lv[5] <= 1'b1;
        wait_cyc(2);
        i_reset <= 1'b0;
        pulse(0);
        irq(1'b1);
        summarize();
    end
endmodule
